/* common/uiom_pkg.sv */
// constants and types of the port and pin-function mux
package uiom_pkg;
	localparam int CLK_HZ            = 10_000_000;
	localparam int SAMPLE_PERIOD_US  = 1000;
	localparam int SAMPLE_CYCLES     = CLK_HZ / 1_000_000 * SAMPLE_PERIOD_US;
	localparam int PWR_SETTLE_NS     = 2000;
	localparam int PWR_SETTLE_CYCLES = (PWR_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int I2C_MIN_KBPS      = 10;
	localparam int I2C_MAX_KBPS      = 1000;
	localparam int I2C_HALF_W        = 10;
	localparam logic [9:0] I2C_HALF_MAX = 10'(CLK_HZ / (2 * 1000 * I2C_MIN_KBPS));
	localparam logic [9:0] I2C_HALF_MIN = 10'(CLK_HZ / (2 * 1000 * I2C_MAX_KBPS));
	localparam int PORT_W           = 32;
	localparam logic [31:0] PORT_RESET   = 32'hFFFF_FFFF;
	localparam logic [31:0] EXIST_NATIVE = 32'h8003_FFFF;
	localparam logic [31:0] EXIST_LEGACY = 32'h0002_FFFF;
	localparam int FIRST_PORT_LSB   = 0;
	localparam int SECOND_PORT_LSB  = 8;
	localparam int THIRD_PORT_LSB   = 16;
	localparam int FOURTH_PORT_BIT  = 31;
	localparam int PWR_BIT_NATIVE   = 31;
	localparam int PWR_BIT_LEGACY   = 17;
	localparam int SCL_BIT_NATIVE   = 17;
	localparam int SDA_BIT_NATIVE   = 16;
	localparam int SCL_BIT_LEGACY   = 1;
	localparam int SDA_BIT_LEGACY   = 2;
	localparam int DISP_ON_BIT      = 4;
	localparam int DISP_REG_SEL_BIT = 5;
	localparam int DISP_DATA_LSB    = 8;
	localparam int ADC_LSB          = 8;
	localparam int MTX_LSB          = 1;
	localparam int MTX_OE_BIT       = 3;
	localparam int DLED_BIT         = 1;
	localparam logic [1:0] IFACE_PINS = 2'h0;
	localparam logic [6:0] LEN_PORT   = 7'h04;
	localparam logic [6:0] LEN_SF     = 7'h40;
	localparam logic [2:0] EP_REPLY_BASE = 3'h2;
	localparam int ADC_RES_W        = 12;
	typedef enum logic [1:0] {ADC_SRC_PIN, ADC_SRC_REF, ADC_SRC_TEMP, ADC_SRC_SUPPLY} uiom_adc_src_t;
	typedef enum logic {PWR_SETTLE, PWR_RUN} uiom_pwr_t;
	typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_RISE, SCL_HIGH} uiom_scl_ph_t;
endpackage

/* common/uiom_scl_if.sv */
// link between the mux and its two-wire clock generator
`timescale 1ns/10ps
`default_nettype none
interface uiom_scl_if;
	logic [9:0] half;
	logic       run;
	logic       scl_level;
	logic       sda_level;
	logic       sda_rel;
	logic       scl_low;
	logic       tick;
	modport gen (input half, run, scl_level, sda_level, sda_rel, output scl_low, tick);
	modport ctl (output half, run, scl_level, sda_level, sda_rel, input scl_low, tick);
endinterface
`default_nettype wire

/* rtl/uiom_port_mux.sv */
// port and pin-function mux of a HID general-purpose I/O controller
// Notes on behaviour
// - first port pins are port word bits 0 to 7.
// - second port pins are port word bits 8 to 15.
// - third port pins are bits 16 and 17; legacy lacks bit 16.
// - fourth port single pin, also power select, is bit 31; legacy has no bit 31 and takes power select from bit 17.
// - power select pin sampled before pull-ups on; high means 500 mA.
// - legacy samples its power pin with a brief pull-down; then normal I/O.
// - pins owned by an active function ignore generic port writes.
// - two-wire clock on third port upper pin, data on lower; legacy uses pins 1,2.
// - two-wire bit rate selectable from 10 to 1000 kbit/s.
// - two-wire clock waits for bus lines to settle before advancing.
// - display uses first port pins 4 to 7 and second port as data.
// - display power enable low while enabled, high when off or suspended.
// - ADC takes second port pins 0 to 3; only 0, 1, 2, 4 channels.
// - ADC gives 12-bit results; reference and temperature sensor selectable.
// - LED matrix uses first port pins 1 to 4 through shift registers.
// - matrix output enable released high in suspend; driver then blanks.
// - LED matrix and addressable LED chain never active together.
// - addressable LED chain driven from first port pin 1.
// - interface 0 pins, 1 special functions, 2 two-wire, 3 ADC.
// - pin writes are four-byte reports; function reports are 64 bytes.
// - input change queues a report on endpoint 1, sent on poll.
// - function replies go out on endpoints 2, 3 or 4.
// - pins sampled once per millisecond; owned pins report high.
// - suspend releases every pin high.
`timescale 1ns/10ps
`default_nettype none
module uiom_port_mux #(
	parameter bit LEGACY        = 1'b0,
	parameter int SAMPLE_CYCLES = uiom_pkg::SAMPLE_CYCLES
) (
	input  wire logic                            sys_clk_in,
	input  wire logic                            reset_in,
	input  wire logic [31:0]                     pin_level_in,
	output logic      [31:0]                     pin_out,
	output logic      [31:0]                     pin_oe_out,
	output logic                                 pull_up_en_out,
	output logic                                 pull_down_en_out,
	output logic                                 high_power_out,
	input  wire logic                            suspend_in,
	input  wire logic                            cmd_valid_in,
	input  wire logic [1:0]                      cmd_iface_in,
	input  wire logic [6:0]                      cmd_len_in,
	input  wire logic [31:0]                     cmd_word_in,
	output logic                                 cmd_refused_out,
	output logic      [2:0]                      sf_cmd_valid_out,
	input  wire logic                            i2c_en_in,
	input  wire logic [9:0]                      i2c_half_in,
	input  wire logic                            i2c_sda_low_in,
	output logic                                 i2c_bit_tick_out,
	input  wire logic                            lcd_en_in,
	input  wire logic [2:0]                      lcd_ctl_in,
	input  wire logic [7:0]                      display_data_bus_in,
	input  wire logic                            adc_en_in,
	input  wire logic [2:0]                      adc_chan_cnt_in,
	input  wire uiom_pkg::uiom_adc_src_t         adc_src_in,
	input  wire logic                            adc_done_in,
	input  wire logic [uiom_pkg::ADC_RES_W-1:0]  adc_raw_in,
	output logic                                 adc_cfg_err_out,
	output logic      [uiom_pkg::ADC_RES_W-1:0]  adc_result_out,
	output uiom_pkg::uiom_adc_src_t              adc_result_src_out,
	input  wire logic                            mtx_en_in,
	input  wire logic [3:0]                      mtx_pins_in,
	input  wire logic                            dled_en_in,
	input  wire logic                            dled_dout_in,
	output logic                                 led_conflict_out,
	input  wire logic                            ep1_poll_in,
	output logic                                 ep1_valid_out,
	output logic      [31:0]                     ep1_report_out,
	input  wire logic [2:0]                      sf_reply_valid_in,
	output logic      [2:0]                      sf_reply_ready_out,
	output logic                                 reply_valid_out,
	output logic      [2:0]                      reply_ep_out
);
	localparam int CNT_W   = $clog2(SAMPLE_CYCLES + 1);
	localparam int PWR_BIT = LEGACY ? uiom_pkg::PWR_BIT_LEGACY : uiom_pkg::PWR_BIT_NATIVE;
	localparam int SCL_BIT = LEGACY ? uiom_pkg::SCL_BIT_LEGACY : uiom_pkg::SCL_BIT_NATIVE;
	localparam int SDA_BIT = LEGACY ? uiom_pkg::SDA_BIT_LEGACY : uiom_pkg::SDA_BIT_NATIVE;
	localparam logic [31:0] EXIST = LEGACY ? uiom_pkg::EXIST_LEGACY : uiom_pkg::EXIST_NATIVE;

	typedef struct packed {
		uiom_pkg::uiom_pwr_t     pwr;
		logic [CNT_W-1:0]        cnt;
		logic                    hi_pwr;
		logic [31:0]             port;
		logic [31:0]             oe;
		logic [31:0]             owned;
		logic [31:0]             last;
		logic                    pend;
		logic                    ep1_v;
		logic [31:0]             ep1;
		logic                    refused;
		logic                    i2c;
		logic                    lcd;
		logic                    adc;
		logic                    mtx;
		logic                    dled;
		logic [2:0]              adc_n;
		logic                    adc_err;
		logic                    conflict;
		logic                    rep_v;
		logic [2:0]              rep_ep;
		logic [11:0]             adc_res;
		uiom_pkg::uiom_adc_src_t adc_src;
	} uiom_top_st_t;

	uiom_top_st_t st_r;
	uiom_top_st_t st_nxt;
	uiom_scl_if   sif ();

	function automatic logic [31:0] owned_mask(input logic i2c, input logic lcd, input logic adc,
		input logic mtx, input logic dled, input logic [2:0] an);
		logic [31:0] m;
		m = '0;
		if (i2c) begin
			m[SCL_BIT] = 1'b1;
			m[SDA_BIT] = 1'b1;
		end
		if (lcd) m[uiom_pkg::DISP_ON_BIT +: 12] = 12'hFFF;
		if (adc) m[uiom_pkg::ADC_LSB +: 4] = m[uiom_pkg::ADC_LSB +: 4] | ((4'h1 << an) - 4'h1);
		if (mtx) m[uiom_pkg::MTX_LSB +: 4] = 4'hF;
		if (dled) m[uiom_pkg::DLED_BIT] = 1'b1;
		return m;
	endfunction

	uiom_scl_gen u_scl (
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.bus        (sif.gen)
	);

	logic run;
	logic tick;
	logic [31:0] smp;
	assign run  = st_r.pwr == uiom_pkg::PWR_RUN;
	assign tick = run && st_r.cnt == CNT_W'(SAMPLE_CYCLES - 1);
	assign smp  = (pin_level_in & ~st_r.owned) | st_r.owned | ~EXIST;

	// the clock generator stays clamped inside the supported rate range
	always_comb begin
		sif.half = i2c_half_in;
		if (i2c_half_in < uiom_pkg::I2C_HALF_MIN) sif.half = uiom_pkg::I2C_HALF_MIN;
		if (i2c_half_in > uiom_pkg::I2C_HALF_MAX) sif.half = uiom_pkg::I2C_HALF_MAX;
	end
	assign sif.run       = run && st_r.i2c && !suspend_in;
	assign sif.scl_level = pin_level_in[SCL_BIT];
	assign sif.sda_level = pin_level_in[SDA_BIT];
	assign sif.sda_rel   = !i2c_sda_low_in;

	always_comb begin
		logic [31:0] oe;
		logic [31:0] base;
		logic        wr;
		logic        len_ok;
		oe     = '0;
		base   = st_r.port;
		len_ok = cmd_len_in == (cmd_iface_in == uiom_pkg::IFACE_PINS ? uiom_pkg::LEN_PORT : uiom_pkg::LEN_SF);
		wr     = run && cmd_valid_in && len_ok && cmd_iface_in == uiom_pkg::IFACE_PINS;
		st_nxt         = st_r;
		st_nxt.ep1_v   = 1'b0;
		st_nxt.refused = run ? (cmd_valid_in && !len_ok) : cmd_valid_in;
		st_nxt.rep_v   = 1'b0;
		sf_cmd_valid_out   = '0;
		sf_reply_ready_out = '0;
		unique case (st_r.pwr)
			uiom_pkg::PWR_SETTLE: begin
				st_nxt.cnt = st_r.cnt + CNT_W'(1);
				if (st_r.cnt == CNT_W'(uiom_pkg::PWR_SETTLE_CYCLES - 1)) begin
					st_nxt.hi_pwr = pin_level_in[PWR_BIT];
					st_nxt.pwr    = uiom_pkg::PWR_RUN;
					st_nxt.cnt    = '0;
				end
			end
			uiom_pkg::PWR_RUN: begin
				st_nxt.cnt = tick ? '0 : st_r.cnt + CNT_W'(1);
				if (cmd_valid_in && len_ok && cmd_iface_in != uiom_pkg::IFACE_PINS) begin
					sf_cmd_valid_out[cmd_iface_in - 2'h1] = 1'b1;
				end
				st_nxt.i2c      = i2c_en_in;
				st_nxt.lcd      = lcd_en_in;
				st_nxt.adc      = adc_en_in;
				// a chain already running keeps its pins against a later matrix request
				st_nxt.mtx      = mtx_en_in && !(st_r.dled && dled_en_in);
				st_nxt.dled     = dled_en_in && !st_nxt.mtx;
				st_nxt.conflict = mtx_en_in && dled_en_in;
				st_nxt.adc_err  = 1'b1;
				if (adc_chan_cnt_in inside {3'h0, 3'h1, 3'h2, 3'h4}) begin
					st_nxt.adc_n   = adc_chan_cnt_in;
					st_nxt.adc_err = 1'b0;
				end
				if (adc_done_in && st_r.adc) begin
					st_nxt.adc_res = adc_raw_in;
					st_nxt.adc_src = adc_src_in;
				end
				if (wr) base = (cmd_word_in & ~st_r.owned) | (st_r.port & st_r.owned);
				st_nxt.owned = owned_mask(st_nxt.i2c, st_nxt.lcd, st_nxt.adc, st_nxt.mtx,
					st_nxt.dled, st_nxt.adc_n);
				// owned bits park at one, so a freed pin comes back released
				st_nxt.port = base | st_nxt.owned;
				oe = ~st_nxt.port & EXIST;
				if (st_nxt.i2c) begin
					oe[SCL_BIT] = sif.scl_low;
					oe[SDA_BIT] = i2c_sda_low_in;
				end
				if (st_nxt.lcd) begin
					oe[uiom_pkg::DISP_ON_BIT] = 1'b1;
					oe[uiom_pkg::DISP_REG_SEL_BIT +: 3] = ~lcd_ctl_in;
					oe[uiom_pkg::DISP_DATA_LSB +: 8] = ~display_data_bus_in;
				end
				if (st_nxt.adc) oe[uiom_pkg::ADC_LSB +: 4] = oe[uiom_pkg::ADC_LSB +: 4] & ~st_nxt.owned[uiom_pkg::ADC_LSB +: 4];
				if (st_nxt.mtx) oe[uiom_pkg::MTX_LSB +: 4] = ~mtx_pins_in;
				if (st_nxt.dled) oe[uiom_pkg::DLED_BIT] = !dled_dout_in;
				if (suspend_in) oe = '0;
				if (tick && smp != st_r.last) begin
					st_nxt.last = smp;
					st_nxt.pend = 1'b1;
				end
				if (ep1_poll_in && st_r.pend) begin
					st_nxt.ep1_v = 1'b1;
					st_nxt.ep1   = st_r.last;
					// a change seen in the same cycle stays queued
					st_nxt.pend  = tick && smp != st_r.last;
				end
				for (int i = 0; i < 3; i++) begin
					if (sf_reply_valid_in[i] && !st_nxt.rep_v) begin
						st_nxt.rep_v          = 1'b1;
						st_nxt.rep_ep         = uiom_pkg::EP_REPLY_BASE + 3'(i);
						sf_reply_ready_out[i] = 1'b1;
					end
				end
			end
		endcase
		st_nxt.oe = oe;
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st_r         <= '0;
			st_r.pwr     <= uiom_pkg::PWR_SETTLE;
			st_r.port    <= uiom_pkg::PORT_RESET;
			st_r.last    <= uiom_pkg::PORT_RESET;
			st_r.adc_src <= uiom_pkg::ADC_SRC_PIN;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_out            = '0;
	assign pin_oe_out         = st_r.oe;
	assign pull_up_en_out     = run;
	assign pull_down_en_out   = LEGACY && !run;
	assign high_power_out     = st_r.hi_pwr;
	assign cmd_refused_out    = st_r.refused;
	assign i2c_bit_tick_out   = sif.tick;
	assign adc_cfg_err_out    = st_r.adc_err;
	assign adc_result_out     = st_r.adc_res;
	assign adc_result_src_out = st_r.adc_src;
	assign led_conflict_out   = st_r.conflict;
	assign ep1_valid_out      = st_r.ep1_v;
	assign ep1_report_out     = st_r.ep1;
	assign reply_valid_out    = st_r.rep_v;
	assign reply_ep_out       = st_r.rep_ep;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	a_pullup_after_sample: assert property (st_r.pwr == uiom_pkg::PWR_SETTLE
		|-> !pull_up_en_out && pin_oe_out == '0)
		else $error("pull-ups or drivers on before power sampling");
	a_power_class: assert property ($rose(run) |-> high_power_out == $past(pin_level_in[PWR_BIT]))
		else $error("power class not taken from the select pin");
	a_suspend_release: assert property (suspend_in && run |=> pin_oe_out == '0)
		else $error("pin still driven in suspend");
	a_disp_power_low: assert property (lcd_en_in && run && !suspend_in
		|=> pin_oe_out[uiom_pkg::DISP_ON_BIT])
		else $error("display power enable not low");
	a_write_blocked: assert property (run && st_r.owned[SCL_BIT] && $stable(st_r.owned)
		|=> st_r.port[SCL_BIT])
		else $error("owned pin changed by a port write");
	a_led_exclusive: assert property (!(st_r.mtx && st_r.dled))
		else $error("matrix and chain active together");
	a_owned_high: assert property (tick && smp != st_r.last |=> (st_r.last & $past(st_r.owned)) == $past(st_r.owned))
		else $error("owned pin not reported high");
	a_report_poll: assert property (ep1_poll_in && st_r.pend && run |=> ep1_valid_out ##1 !ep1_valid_out)
		else $error("queued report not sent on poll");
	a_reply_ep: assert property (run && sf_reply_valid_in[0] |=> reply_valid_out && reply_ep_out == 3'h2)
		else $error("reply on wrong endpoint");
endmodule // uiom_port_mux
`default_nettype wire

/* rtl/uiom_scl_gen.sv */
// two-wire clock generator that waits for the bus lines to settle
`timescale 1ns/10ps
`default_nettype none
module uiom_scl_gen (
	input  wire logic      sys_clk_in,
	input  wire logic      reset_in,
	uiom_scl_if.gen        bus
);
	typedef struct packed {
		uiom_pkg::uiom_scl_ph_t ph;
		logic [9:0]             cnt;
		logic                   scl_low;
		logic                   tick;
	} uiom_scl_st_t;

	uiom_scl_st_t st_r;
	uiom_scl_st_t st_nxt;

	assign bus.scl_low = st_r.scl_low;
	assign bus.tick    = st_r.tick;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		unique case (st_r.ph)
			uiom_pkg::SCL_IDLE: begin
				st_nxt.scl_low = 1'b0;
				st_nxt.cnt     = '0;
				if (bus.run) begin
					st_nxt.ph      = uiom_pkg::SCL_LOW;
					st_nxt.scl_low = 1'b1;
				end
			end
			uiom_pkg::SCL_LOW: begin
				st_nxt.cnt = st_r.cnt + 10'h001;
				if (!bus.run) begin
					st_nxt.ph      = uiom_pkg::SCL_IDLE;
					st_nxt.scl_low = 1'b0;
				end else if (st_r.cnt >= bus.half - 10'h001) begin
					st_nxt.ph      = uiom_pkg::SCL_RISE;
					st_nxt.scl_low = 1'b0;
					st_nxt.cnt     = '0;
				end
			end
			uiom_pkg::SCL_RISE: begin
				// a slow edge stretches the cycle instead of corrupting it
				if (bus.scl_level && bus.sda_level == bus.sda_rel) begin
					st_nxt.ph = uiom_pkg::SCL_HIGH;
				end
			end
			uiom_pkg::SCL_HIGH: begin
				st_nxt.cnt = st_r.cnt + 10'h001;
				if (st_r.cnt >= bus.half - 10'h001) begin
					st_nxt.tick    = 1'b1;
					st_nxt.cnt     = '0;
					st_nxt.ph      = bus.run ? uiom_pkg::SCL_LOW : uiom_pkg::SCL_IDLE;
					st_nxt.scl_low = bus.run;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st_r <= '{ph: uiom_pkg::SCL_IDLE, cnt: 10'h000, scl_low: 1'b0, tick: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	a_scl_wait_settle: assert property ((st_r.ph == uiom_pkg::SCL_RISE && !bus.scl_level)
		|=> st_r.ph == uiom_pkg::SCL_RISE && !st_r.tick)
		else $error("clock advanced before the line settled");
	a_tick_after_high: assert property (st_r.tick |-> $past(st_r.ph) == uiom_pkg::SCL_HIGH
		&& $past(bus.scl_level, 2))
		else $error("bit tick without a settled high phase");
endmodule // uiom_scl_gen
`default_nettype wire

/* test/test_usb_io_port_function_mux.sv */
// self-checking bench of the port and pin-function mux
`timescale 1ns/10ps
`default_nettype none
module test_usb_io_port_function_mux;
	localparam int SC = 50;
	logic                   sys_clk = 1'b0;
	logic                   rst     = 1'b1;
	logic [31:0]            ext_low = 32'h0;
	logic                   susp    = 1'b0;
	logic                   i2c_en  = 1'b0;
	logic                   lcd_en  = 1'b0;
	logic [2:0]             lcd_ctl = 3'h0;
	logic [7:0]             lcd_dat = 8'h00;
	logic                   adc_en  = 1'b0;
	logic [2:0]             chan    = 3'h0;
	uiom_pkg::uiom_adc_src_t src    = uiom_pkg::ADC_SRC_PIN;
	logic                   done    = 1'b0;
	logic [11:0]            raw     = 12'h000;
	logic                   mtx_en  = 1'b0;
	logic [3:0]             mtx_pins = 4'h0;
	logic                   dled_en = 1'b0;
	logic                   dled_do = 1'b0;
	logic                   pd;
	logic [2:0]             rpl     = 3'h0;
	logic [31:0]            oe, ep1r;
	logic                   pu, hp, refused, tick, cfg_err, conflict, ep1v, rv;
	logic [2:0]             sfv, rdy, rep;
	logic [11:0]            res;
	uiom_pkg::uiom_adc_src_t res_src;
	logic                   cv, poll;
	logic [1:0]             ci;
	logic [6:0]             cl;
	logic [31:0]            cw;
	int                     fail_count = 0;
	int                     checked = 0;
	// open-drain lines with pull-ups, optionally held low from outside
	wire logic [31:0]       lvl = ~oe & ~ext_low;
	wire logic [3:0]        pul = {rv, ep1v, tick, refused};

	always #50 sys_clk = ~sys_clk;

	uiom_host_model i_uiom_host_model (.sys_clk_in(sys_clk), .cmd_valid_out(cv), .cmd_iface_out(ci),
		.cmd_len_out(cl), .cmd_word_out(cw), .ep1_poll_out(poll));

	uiom_port_mux #(.LEGACY(1'b0), .SAMPLE_CYCLES(SC)) i_uiom_port_mux (.sys_clk_in(sys_clk), .reset_in(rst),
		.pin_level_in(lvl), .pin_out(), .pin_oe_out(oe), .pull_up_en_out(pu), .pull_down_en_out(pd),
		.high_power_out(hp), .suspend_in(susp), .cmd_valid_in(cv), .cmd_iface_in(ci), .cmd_len_in(cl),
		.cmd_word_in(cw), .cmd_refused_out(refused), .sf_cmd_valid_out(sfv), .i2c_en_in(i2c_en),
		.i2c_half_in(10'h005), .i2c_sda_low_in(1'b0), .i2c_bit_tick_out(tick), .lcd_en_in(lcd_en),
		.lcd_ctl_in(lcd_ctl), .display_data_bus_in(lcd_dat), .adc_en_in(adc_en), .adc_chan_cnt_in(chan),
		.adc_src_in(src), .adc_done_in(done), .adc_raw_in(raw), .adc_cfg_err_out(cfg_err),
		.adc_result_out(res), .adc_result_src_out(res_src), .mtx_en_in(mtx_en), .mtx_pins_in(mtx_pins),
		.dled_en_in(dled_en), .dled_dout_in(dled_do), .led_conflict_out(conflict), .ep1_poll_in(poll),
		.ep1_valid_out(ep1v), .ep1_report_out(ep1r), .sf_reply_valid_in(rpl), .sf_reply_ready_out(rdy),
		.reply_valid_out(rv), .reply_ep_out(rep));

	task test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task wait_bit(input int b, input int lim, input string nm);
		int n;
		n = 0;
		while (pul[b] !== 1'b1 && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		if (pul[b] !== 1'b1) begin
			chk(nm, 32'h1, 32'h0);
			test_done;
		end
	endtask
	task t_reset(input logic l);
		@(posedge sys_clk);
		ext_low <= {~l, 31'h0};
		rst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		#1 chk("pull_up_en", 32'h0, 32'(pu));
		chk("pull_down_en", 32'h0, 32'(pd));
		repeat (12) @(posedge sys_clk);
		#1 chk("high_power", 32'(l), 32'(hp));
		chk("pull_up_en", 32'h1, 32'(pu));
		@(posedge sys_clk);
		ext_low <= 32'h0;
	endtask
	task t_port;
		i_uiom_host_model.send(2'h0, uiom_pkg::LEN_PORT, 32'h7FFC_A55A);
		i_uiom_host_model.drop();
		repeat (2) @(posedge sys_clk);
		#1 chk("pin_oe", ~32'h7FFC_A55A & uiom_pkg::EXIST_NATIVE, oe);
		i_uiom_host_model.send(2'h0, uiom_pkg::LEN_SF, 32'h0);
		i_uiom_host_model.drop();
		wait_bit(0, 4, "cmd_refused");
		for (int i = 1; i < 4; i++) begin
			i_uiom_host_model.send(2'(i), uiom_pkg::LEN_SF, 32'h0);
			chk("sf_cmd_valid", 32'h1 << (i - 1), 32'(sfv));
			i_uiom_host_model.drop();
		end
		repeat (2) @(posedge sys_clk);
		#1 chk("pin_oe kept", ~32'h7FFC_A55A & uiom_pkg::EXIST_NATIVE, oe);
	endtask
	task t_lcd;
		i_uiom_host_model.send(2'h0, uiom_pkg::LEN_PORT, 32'h0);
		i_uiom_host_model.drop();
		lcd_ctl <= 3'b010;
		lcd_dat <= 8'h3C;
		lcd_en <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk("pin_oe display", 32'h8003_C3BF, oe);
		@(posedge sys_clk);
		susp <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk("pin_oe suspend", 32'h0, oe);
		@(posedge sys_clk);
		susp <= 1'b0;
		lcd_en <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 chk("pin_oe freed", 32'h0, 32'(oe[15:4]));
	endtask
	task t_i2c;
		int n;
		@(posedge sys_clk);
		i2c_en <= 1'b1;
		wait_bit(1, 100, "bit_tick");
		i_uiom_host_model.send(2'h0, uiom_pkg::LEN_PORT, 32'h0);
		i_uiom_host_model.drop();
		repeat (2) @(posedge sys_clk);
		#1 chk("data pin released", 32'h0, 32'(oe[16]));
		@(posedge sys_clk);
		ext_low[16] <= 1'b1;
		repeat (10) @(posedge sys_clk);
		n = 0;
		repeat (60) begin
			@(negedge sys_clk);
			if (tick === 1'b1) n++;
		end
		chk("ticks while held", 32'h0, 32'(n));
		@(posedge sys_clk);
		ext_low[16] <= 1'b0;
		wait_bit(1, 100, "bit_tick resumed");
		@(posedge sys_clk);
		i2c_en <= 1'b0;
	endtask
	task t_adc;
		@(posedge sys_clk);
		adc_en <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			@(posedge sys_clk);
			chan <= 3'(c);
			repeat (2) @(posedge sys_clk);
			#1 chk("adc_cfg_err", 32'(!(c inside {0, 1, 2, 4})), 32'(cfg_err));
		end
		for (int s = 0; s < 4; s++) begin
			@(posedge sys_clk);
			src <= uiom_pkg::uiom_adc_src_t'(s);
			raw <= 12'hA50 + 12'(s);
			done <= 1'b1;
			@(posedge sys_clk);
			done <= 1'b0;
			@(posedge sys_clk);
			#1 chk("adc_result", 32'h0000_0A50 + 32'(s), 32'(res));
			chk("adc_result_src", 32'(s), 32'(res_src));
		end
		@(posedge sys_clk);
		adc_en <= 1'b0;
		chan <= 3'h4;
	endtask
	task t_input;
		int n;
		i_uiom_host_model.send(2'h0, uiom_pkg::LEN_PORT, 32'hFFFF_FFFF);
		i_uiom_host_model.drop();
		ext_low[9] <= 1'b1;
		repeat (2 * SC + 5) @(posedge sys_clk);
		i_uiom_host_model.poll();
		wait_bit(2, 5, "ep1_valid");
		chk("ep1_report", 32'hFFFF_FDFF, ep1r);
		i_uiom_host_model.poll();
		n = 0;
		repeat (4) begin
			@(negedge sys_clk);
			if (ep1v === 1'b1) n++;
		end
		chk("ep1 without change", 32'h0, 32'(n));
		@(posedge sys_clk);
		adc_en <= 1'b1;
		repeat (2 * SC + 5) @(posedge sys_clk);
		i_uiom_host_model.poll();
		wait_bit(2, 5, "ep1_valid owned");
		chk("ep1_report owned", 32'hFFFF_FFFF, ep1r);
		@(posedge sys_clk);
		adc_en <= 1'b0;
		ext_low <= 32'h0;
	endtask
	task t_led;
		@(posedge sys_clk);
		mtx_pins <= 4'b1011;
		mtx_en <= 1'b1;
		dled_en <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk("led_conflict", 32'h1, 32'(conflict));
		chk("matrix pins", 32'h4, 32'(oe[4:1]));
		@(posedge sys_clk);
		susp <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk("pin_oe suspend", 32'h0, oe);
		@(posedge sys_clk);
		susp <= 1'b0;
		mtx_en <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 chk("chain pin", 32'h1, 32'(oe[1]));
		@(posedge sys_clk);
		dled_do <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk("chain pin high", 32'h0, 32'(oe[1]));
		@(posedge sys_clk);
		dled_do <= 1'b0;
		dled_en <= 1'b0;
	endtask
	task t_reply;
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			rpl <= 3'(3'b111 << k);
			@(negedge sys_clk);
			chk("reply_ready", 32'h1 << k, 32'(rdy));
			@(posedge sys_clk);
			rpl <= 3'h0;
			wait_bit(3, 4, "reply_valid");
			chk("reply_ep", 32'(2 + k), 32'(rep));
		end
	endtask

	initial begin
		t_reset(1'b0);
		t_reset(1'b1);
		t_port;
		t_lcd;
		t_i2c;
		t_adc;
		t_input;
		t_led;
		t_reply;
		test_done;
	end
endmodule // test_usb_io_port_function_mux
`default_nettype wire

/* test/uiom_host_model.sv */
// host model issuing pin and function reports and endpoint polls
`timescale 1ns/10ps
`default_nettype none
module uiom_host_model (
	input  wire logic        sys_clk_in,
	output logic             cmd_valid_out,
	output logic [1:0]       cmd_iface_out,
	output logic [6:0]       cmd_len_out,
	output logic [31:0]      cmd_word_out,
	output logic             ep1_poll_out
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_iface_out = 2'h0;
		cmd_len_out   = 7'h00;
		cmd_word_out  = 32'h0000_0000;
		ep1_poll_out  = 1'b0;
	end
	// raises a report and returns mid-cycle so the caller sees the same-cycle answer
	task send(input logic [1:0] i, input logic [6:0] n, input logic [31:0] w);
		@(posedge sys_clk_in);
		cmd_valid_out <= 1'b1;
		cmd_iface_out <= i;
		cmd_len_out   <= n;
		cmd_word_out  <= w;
		@(negedge sys_clk_in);
	endtask
	task drop;
		@(posedge sys_clk_in);
		cmd_valid_out <= 1'b0;
	endtask
	// the device never pushes input reports; endpoint 1 data leaves only on a poll, function replies need none
	task poll;
		@(posedge sys_clk_in);
		ep1_poll_out <= 1'b1;
		@(posedge sys_clk_in);
		ep1_poll_out <= 1'b0;
	endtask
endmodule // uiom_host_model
`default_nettype wire
